// ### core/tmrb_consts.svh
// register map, field positions, reset values and counts of the timer block
`ifndef TMRB_CONSTS_SVH
`define TMRB_CONSTS_SVH
`define TMRB_OFS_START   8'h00
`define TMRB_OFS_MODE    8'h04
`define TMRB_OFS_CNT     8'h10
`define TMRB_OFS_STAT    8'h1C
`define TMRB_OFS_MASK    8'h20
`define TMRB_BANK_SPAN   8'h0C
`define TMRB_WORD_SHIFT  2
`define TMRB_OVF_BIT     5
`define TMRB_MODE_RST    8'h00
`define TMRB_CNT_RST     16'h0000
`define TMRB_ALL_ONES    16'hFFFF
`define TMRB_PRE_W       5
`define TMRB_RESP_OKAY   2'h0
`define TMRB_RESP_SLVERR 2'h2
`endif

// ### core/tmrb_pkg.sv
// types shared by the timer block files
package tmrb_pkg;
   typedef enum logic [1:0] {
      TMRB_OP_TIMER = 2'h0,
      TMRB_OP_EVENT = 2'h1,
      TMRB_OP_MEAS  = 2'h2,
      TMRB_OP_RSVD  = 2'h3
   } tmrb_op_e;
   // timer_mode_reg layout, bits 7 down to 0
   typedef struct packed {
      logic [1:0] count_source;
      logic       overflow_flag;
      logic       mode_aux_bit;
      logic       function_select_high;
      logic       function_select_low;
      tmrb_op_e   operating_mode;
   } tmrb_mode_s;
   // per-timer state seen by the register file
   typedef struct packed {
      logic [15:0] rd;
      logic        ovf;
      logic        irq;
   } tmrb_chan_st_s;
endpackage

// ### core/tmrb_chan.sv
// one 16-bit timer: timer, event counter and pulse measurement modes
`timescale 1ns/1ps
`include "tmrb_consts.svh"
module tmrb_chan (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   // control
   input  wire logic                   run,
   input  wire tmrb_pkg::tmrb_mode_s   mode,
   input  wire logic                   tick,
   input  wire logic                   pin,
   // software writes
   input  wire logic                   wr_cnt,
   input  wire logic [15:0]            wdata,
   input  wire logic                   clr_ovf,
   // state
   output      tmrb_pkg::tmrb_chan_st_s st
);
   logic        pin_ff;
   logic [15:0] cnt_ff;
   logic [15:0] rld_ff;
   logic        ovf_ff;
   logic        ovf_seen_ff;
   logic        seen_ff;
   logic        meas;
   logic        edge_hit_now;
   logic        cnt_en;
   logic        reload_now;
   logic        ovf_now;
   logic        meas_edge;

   // falling, rising, or both edges
   function automatic logic edge_hit(input logic [1:0] fs, input logic now, input logic was);
      case (fs)
         2'h0:    edge_hit = was & ~now;
         2'h1:    edge_hit = now & ~was;
         default: edge_hit = now ^ was;
      endcase
   endfunction

   assign meas         = (mode.operating_mode == tmrb_pkg::TMRB_OP_MEAS);
   assign edge_hit_now = edge_hit({mode.function_select_high, mode.function_select_low},
                                  pin, pin_ff);
   assign cnt_en       = (mode.operating_mode == tmrb_pkg::TMRB_OP_EVENT) ? edge_hit_now : tick;
   assign reload_now   = run && !meas && cnt_en && (cnt_ff == `TMRB_CNT_RST);
   assign ovf_now      = run && meas && tick && (cnt_ff == `TMRB_ALL_ONES);
   assign meas_edge    = run && meas && edge_hit_now;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_ff <= 1'b0;
      end else begin
         pin_ff <= pin;
      end
   end

   // counter not cleared at start: measurement begins from whatever it holds
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= `TMRB_CNT_RST;
      end else if (!run) begin
         if (wr_cnt && !meas) begin
            cnt_ff <= wdata;
         end
      end else if (meas) begin
         if (meas_edge) begin
            cnt_ff <= `TMRB_CNT_RST;
         end else if (tick) begin
            cnt_ff <= cnt_ff + 16'h0001;
         end
      end else if (cnt_en) begin
         cnt_ff <= reload_now ? rld_ff : cnt_ff - 16'h0001;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rld_ff <= `TMRB_CNT_RST;
      end else if (meas_edge) begin
         rld_ff <= cnt_ff;
      end else if (wr_cnt && !meas) begin
         rld_ff <= wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         seen_ff <= 1'b0;
      end else if (!run || !meas) begin
         seen_ff <= 1'b0;
      end else if (meas_edge) begin
         seen_ff <= 1'b1;
      end
   end

   // set wins over clear; clear needs run and one counted tick since set
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ovf_ff <= 1'b0;
      end else if (ovf_now) begin
         ovf_ff <= 1'b1;
      end else if (clr_ovf && run && ovf_seen_ff) begin
         ovf_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ovf_seen_ff <= 1'b0;
      end else if (!ovf_ff) begin
         ovf_seen_ff <= 1'b0;
      end else if (run && tick) begin
         ovf_seen_ff <= 1'b1;
      end
   end

   assign st.irq = reload_now || ovf_now || (meas_edge && seen_ff);
   assign st.ovf = ovf_ff;
   assign st.rd  = meas ? rld_ff : (reload_now ? `TMRB_ALL_ONES : cnt_ff);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_idle_holds_count: assert property (!run && !wr_cnt |=> $stable(cnt_ff))
      else $error("stopped timer changed its count");
   a_reload_reads_ones: assert property (
      run && !meas && cnt_en && cnt_ff == `TMRB_CNT_RST
      |-> st.rd == `TMRB_ALL_ONES ##1 cnt_ff == $past(rld_ff))
      else $error("reload cycle did not read all ones");
   a_written_readback: assert property (
      !run && !meas && wr_cnt ##1 !run && !wr_cnt && !meas |-> st.rd == $past(wdata))
      else $error("written count not read back");
   a_edge_sets_irq: assert property (meas_edge && seen_ff |-> st.irq)
      else $error("measured edge without request");
   a_ovf_sets_flag: assert property (ovf_now |=> ovf_ff)
      else $error("overflow not recorded");
   a_ovf_clear_guard: assert property (
      ovf_ff && !ovf_seen_ff && !ovf_now |=> ovf_ff)
      else $error("overflow flag cleared too early");
   a_first_edge_quiet: assert property (meas_edge && !seen_ff && !ovf_now |-> !st.irq)
      else $error("first edge raised a request");
   a_early_ovf_irq: assert property (ovf_now && !seen_ff |-> st.irq)
      else $error("early overflow gave no request");
   a_width_both_edges: assert property (
      run && meas && mode.function_select_high && (pin != pin_ff)
      |=> cnt_ff == `TMRB_CNT_RST && rld_ff == $past(cnt_ff))
      else $error("width edge did not restart count");
endmodule

// ### core/tmrb_top.sv
// three 16-bit timers behind an axi4-lite register slave
//
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`include "tmrb_consts.svh"
module tmrb_top #(
   parameter int N_TMR  = 3,
   parameter int ADDR_W = 8
) (
   // clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rstn,
   // write address channel
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output      logic              s_axi_awready,
   // write data channel
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output      logic              s_axi_wready,
   // write response channel
   output      logic [1:0]        s_axi_bresp,
   output      logic              s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // read address channel
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output      logic              s_axi_arready,
   // read data channel
   output      logic [31:0]       s_axi_rdata,
   output      logic [1:0]        s_axi_rresp,
   output      logic              s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // measured pulse or event inputs
   input  wire logic [N_TMR-1:0]  tmr_pin,
   // interrupt
   output      logic              irq
);
   logic                          rst_meta_ff;
   logic                          rst_n_ff;
   logic                          awready_ff;
   logic                          wready_ff;
   logic                          bvalid_ff;
   logic [1:0]                    bresp_ff;
   logic                          arready_ff;
   logic                          rvalid_ff;
   logic [31:0]                   rdata_ff;
   logic [1:0]                    rresp_ff;
   logic                          aw_full_ff;
   logic                          w_full_ff;
   logic [7:0]                    awaddr_ff;
   logic [31:0]                   wdata_ff;
   logic [3:0]                    wstrb_ff;
   logic [N_TMR-1:0]              run_ff;
   tmrb_pkg::tmrb_mode_s          mode_ff [N_TMR];
   logic [N_TMR-1:0]              stat_ff;
   logic [N_TMR-1:0]              mask_ff;
   logic                          irq_ff;
   logic [`TMRB_PRE_W-1:0]        pre_ff;
   logic [3:0]                    tick_vec;
   logic                          wr_go;
   logic                          wr_start;
   logic                          wr_stat;
   logic                          wr_mask;
   logic [N_TMR-1:0]              wr_mode;
   logic [N_TMR-1:0]              wr_cnt;
   logic [N_TMR-1:0]              ch_irq;
   logic                          rd_go;
   tmrb_pkg::tmrb_chan_st_s       ch_st [N_TMR];
   logic [7:0]                    ra;

   // address falls in a three-word bank
   function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
      in_bank = (a >= base) && (a < base + `TMRB_BANK_SPAN) && (a[1:0] == 2'h0);
   endfunction

   function automatic logic [1:0] bank_idx(input logic [7:0] a, input logic [7:0] base);
      logic [7:0] d;
      d = a - base;
      bank_idx = d[`TMRB_WORD_SHIFT+1:`TMRB_WORD_SHIFT];
   endfunction

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] nw,
                                           input logic [3:0] strb);
      merge16 = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
   endfunction

   // reset release through two flops
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_ff <= 1'b0;
         rst_n_ff    <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n_ff    <= rst_meta_ff;
      end
   end

   // write address and data taken in either order
   always_ff @(posedge ref_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         awready_ff <= 1'b0;
         aw_full_ff <= 1'b0;
         awaddr_ff  <= 8'h00;
      end else if (s_axi_awvalid && awready_ff) begin
         awready_ff <= 1'b0;
         aw_full_ff <= 1'b1;
         awaddr_ff  <= 8'(s_axi_awaddr);
      end else if (wr_go) begin
         aw_full_ff <= 1'b0;
      end else if (!aw_full_ff && !bvalid_ff) begin
         awready_ff <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         wready_ff <= 1'b0;
         w_full_ff <= 1'b0;
         wdata_ff  <= 32'h00000000;
         wstrb_ff  <= 4'h0;
      end else if (s_axi_wvalid && wready_ff) begin
         wready_ff <= 1'b0;
         w_full_ff <= 1'b1;
         wdata_ff  <= s_axi_wdata;
         wstrb_ff  <= s_axi_wstrb;
      end else if (wr_go) begin
         w_full_ff <= 1'b0;
      end else if (!w_full_ff && !bvalid_ff) begin
         wready_ff <= 1'b1;
      end
   end

   assign wr_go    = aw_full_ff && w_full_ff && !bvalid_ff;
   assign wr_start = wr_go && (awaddr_ff == `TMRB_OFS_START) && wstrb_ff[0];
   assign wr_stat  = wr_go && (awaddr_ff == `TMRB_OFS_STAT) && wstrb_ff[0];
   assign wr_mask  = wr_go && (awaddr_ff == `TMRB_OFS_MASK) && wstrb_ff[0];

   always_ff @(posedge ref_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= `TMRB_RESP_OKAY;
      end else if (wr_go) begin
         bvalid_ff <= 1'b1;
         if (awaddr_ff == `TMRB_OFS_START || awaddr_ff == `TMRB_OFS_STAT
             || awaddr_ff == `TMRB_OFS_MASK || in_bank(awaddr_ff, `TMRB_OFS_MODE)
             || in_bank(awaddr_ff, `TMRB_OFS_CNT)) begin
            bresp_ff <= `TMRB_RESP_OKAY;
         end else begin
            bresp_ff <= `TMRB_RESP_SLVERR;
         end
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   // timers stay stopped until software sets a start bit
   always_ff @(posedge ref_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         run_ff <= '0;
      end else if (wr_start) begin
         run_ff <= wdata_ff[N_TMR-1:0];
      end
   end

   // free-running prescaler feeding the count sources
   always_ff @(posedge ref_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         pre_ff <= '0;
      end else begin
         pre_ff <= pre_ff + `TMRB_PRE_W'(1);
      end
   end

   assign tick_vec = {&pre_ff[4:0], &pre_ff[2:0], pre_ff[0], 1'b1};

   genvar g;
   generate
      for (g = 0; g < N_TMR; g++) begin : gen_tmr
         assign wr_mode[g] = wr_go && wstrb_ff[0] && in_bank(awaddr_ff, `TMRB_OFS_MODE)
                             && (bank_idx(awaddr_ff, `TMRB_OFS_MODE) == 2'(g));
         assign wr_cnt[g]  = wr_go && in_bank(awaddr_ff, `TMRB_OFS_CNT)
                             && (bank_idx(awaddr_ff, `TMRB_OFS_CNT) == 2'(g));
         assign ch_irq[g]  = ch_st[g].irq;

         // a running timer keeps its mode; only the flag clear acts
         always_ff @(posedge ref_clk or negedge rst_n_ff) begin
            if (!rst_n_ff) begin
               mode_ff[g] <= tmrb_pkg::tmrb_mode_s'(`TMRB_MODE_RST);
            end else if (wr_mode[g] && !run_ff[g]) begin
               mode_ff[g] <= tmrb_pkg::tmrb_mode_s'(wdata_ff[7:0]);
            end
         end

         tmrb_chan tmrb_chan_i (
            .clk     (ref_clk),
            .rst_n   (rst_n_ff),
            .run     (run_ff[g]),
            .mode    (mode_ff[g]),
            .tick    (tick_vec[mode_ff[g].count_source]),
            .pin     (tmr_pin[g]),
            .wr_cnt  (wr_cnt[g]),
            .wdata   (merge16(ch_st[g].rd, wdata_ff, wstrb_ff)),
            .clr_ovf (wr_mode[g] && !wdata_ff[`TMRB_OVF_BIT]),
            .st      (ch_st[g])
         );
      end
   endgenerate

   // requests are sticky; a new request beats a write-one clear
   always_ff @(posedge ref_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         stat_ff <= '0;
      end else if (wr_stat) begin
         stat_ff <= (stat_ff & ~wdata_ff[N_TMR-1:0]) | ch_irq;
      end else begin
         stat_ff <= stat_ff | ch_irq;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         mask_ff <= '0;
      end else if (wr_mask) begin
         mask_ff <= wdata_ff[N_TMR-1:0];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(stat_ff & mask_ff);
      end
   end

   // read path: one read at a time, answer one cycle after address
   assign rd_go = s_axi_arvalid && arready_ff;
   assign ra    = 8'(s_axi_araddr);

   always_ff @(posedge ref_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         arready_ff <= 1'b0;
      end else if (rd_go) begin
         arready_ff <= 1'b0;
      end else if (!rvalid_ff) begin
         arready_ff <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= 32'h00000000;
         rresp_ff  <= `TMRB_RESP_OKAY;
      end else if (rd_go) begin
         rvalid_ff <= 1'b1;
         rresp_ff  <= `TMRB_RESP_OKAY;
         if (ra == `TMRB_OFS_START) begin
            rdata_ff <= 32'(run_ff);
         end else if (ra == `TMRB_OFS_STAT) begin
            rdata_ff <= 32'(stat_ff);
         end else if (ra == `TMRB_OFS_MASK) begin
            rdata_ff <= 32'(mask_ff);
         end else if (in_bank(ra, `TMRB_OFS_MODE)) begin
            rdata_ff <= 32'({mode_ff[bank_idx(ra, `TMRB_OFS_MODE)][7:6],
                             ch_st[bank_idx(ra, `TMRB_OFS_MODE)].ovf,
                             mode_ff[bank_idx(ra, `TMRB_OFS_MODE)][4:0]});
         end else if (in_bank(ra, `TMRB_OFS_CNT)) begin
            rdata_ff <= 32'(ch_st[bank_idx(ra, `TMRB_OFS_CNT)].rd);
         end else begin
            rdata_ff <= 32'h00000000;
            rresp_ff <= `TMRB_RESP_SLVERR;
         end
      end else if (s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   assign s_axi_awready = awready_ff;
   assign s_axi_wready  = wready_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;
   assign irq           = irq_ff;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n_ff);

   a_run_by_write: assert property ($rose(run_ff[0]) |-> $past(wr_start))
      else $error("timer started without a start write");
   a_irq_sticky: assert property (ch_irq[0] |=> stat_ff[0])
      else $error("request did not set status");
   a_irq_output: assert property (
      (stat_ff & mask_ff) != '0 ##1 (stat_ff & mask_ff) != '0 |-> irq)
      else $error("unmasked request not on interrupt");
   a_mode_locked: assert property (run_ff[1] && wr_mode[1] |=> $stable(mode_ff[1]))
      else $error("mode changed while running");
   a_read_answer: assert property (rd_go |=> s_axi_rvalid)
      else $error("read not answered in one cycle");

   a_start_sets_run: assert property (
      wr_start |=> run_ff == $past(wdata_ff[N_TMR-1:0]))
      else $error("start write did not set run bits");
   a_stat_clear: assert property (wr_stat && wdata_ff[0] && !ch_irq[0] |=> !stat_ff[0])
      else $error("status bit not cleared by write one");
   a_mask_blocks: assert property ((stat_ff & mask_ff) == '0 |=> !irq)
      else $error("masked status raised interrupt");
   a_write_answer: assert property (wr_go |=> s_axi_bvalid)
      else $error("write not answered in one cycle");
   a_stopped_idle: assert property (
      !run_ff[2] && !wr_start && !wr_cnt[2] && !wr_mode[2] |=> $stable(ch_st[2].rd))
      else $error("stopped timer changed its readout");
   a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while data pending");
   a_mode_written: assert property (
      wr_mode[0] && !run_ff[0] |=> mode_ff[0] == $past(wdata_ff[7:0]))
      else $error("stopped timer mode write lost");

   c_write_done: cover property (s_axi_bvalid && s_axi_bready);
   c_reload_read: cover property (s_axi_rvalid && s_axi_rdata == 32'h0000FFFF);
   c_irq_raised: cover property ($rose(irq));
   c_ovf_seen: cover property ($rose(ch_st[0].ovf));
   c_meas_request: cover property (run_ff[1] && ch_irq[1]);
endmodule

// ### tb/tmrb_pulse_src.sv
// pulse source standing in for the external measured signal
`timescale 1ns/1ps
module tmrb_pulse_src (
   // clock and control
   input  wire logic       clk,
   input  wire logic       go,
   input  wire logic [7:0] hi_w,
   input  wire logic [7:0] lo_w,
   input  wire logic [7:0] n_per,
   // measured pulse
   output      logic       pin
);
   logic [7:0] ph_ff;
   logic [7:0] np_ff;
   logic       wrap;

   assign wrap = (ph_ff == hi_w + lo_w - 8'h01);

   // high then low, back to back, level never marked
   always_ff @(posedge clk) begin
      if (!go) begin
         ph_ff <= 8'h00;
         np_ff <= 8'h00;
         pin   <= 1'b0;
      end else if (n_per != 8'h00 && np_ff == n_per) begin
         pin <= 1'b0;
      end else begin
         pin   <= (ph_ff < hi_w);
         ph_ff <= wrap ? 8'h00 : ph_ff + 8'h01;
         np_ff <= wrap ? np_ff + 8'h01 : np_ff;
      end
   end
endmodule

// ### tb/tmrb_top_bench.sv
// self-checking bench for the three-timer block
`timescale 1ns/1ps
`include "tmrb_consts.svh"
module tmrb_top_bench;
   localparam logic [7:0] A_M0 = `TMRB_OFS_MODE;
   localparam logic [7:0] A_M1 = `TMRB_OFS_MODE + 8'h04;
   localparam logic [7:0] A_M2 = `TMRB_OFS_MODE + 8'h08;
   localparam logic [7:0] A_C0 = `TMRB_OFS_CNT;
   localparam logic [7:0] A_C1 = `TMRB_OFS_CNT + 8'h04;
   localparam logic [7:0] A_C2 = `TMRB_OFS_CNT + 8'h08;
   logic        ref_clk;
   logic        rstn;
   logic [7:0]  s_axi_awaddr;
   logic        s_axi_awvalid;
   logic        s_axi_awready;
   logic [31:0] s_axi_wdata;
   logic [3:0]  s_axi_wstrb;
   logic        s_axi_wvalid;
   logic        s_axi_wready;
   logic [1:0]  s_axi_bresp;
   logic        s_axi_bvalid;
   logic        s_axi_bready;
   logic [7:0]  s_axi_araddr;
   logic        s_axi_arvalid;
   logic        s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0]  s_axi_rresp;
   logic        s_axi_rvalid;
   logic        s_axi_rready;
   logic        irq;
   logic        pin;
   logic        go;
   logic [7:0]  hi_w;
   logic [7:0]  lo_w;
   logic [7:0]  n_per;
   logic [31:0] rd_v;
   logic [1:0]  rsp;
   int          n_fail;
   int          n_compared;
   int          n_cyc;

   tmrb_top #(.N_TMR(3), .ADDR_W(8)) tmrb_top_i (
      .ref_clk(ref_clk), .rstn(rstn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .tmr_pin({3{pin}}), .irq(irq));

   tmrb_pulse_src tmrb_pulse_src_i (
      .clk(ref_clk), .go(go), .hi_w(hi_w), .lo_w(lo_w), .n_per(n_per), .pin(pin));

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   task automatic complete_run();
      if (n_fail == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   always @(posedge ref_clk) begin
      n_cyc <= n_cyc + 1;
      if (n_cyc == 6000) begin
         n_fail++;
         complete_run();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // both channels offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd_v = s_axi_rdata;
      rsp  = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic t_reset();
      rd(`TMRB_OFS_START);
      chk(rd_v, 32'h0);
      rd(A_M0);
      chk(rd_v, {24'h0, `TMRB_MODE_RST});
      rd(A_C0);
      chk(rd_v, {16'h0, `TMRB_CNT_RST});
      rd(8'h24);
      chk({30'h0, rsp}, {30'h0, `TMRB_RESP_SLVERR});
      wr(8'h30, 32'hFFFF_FFFF);
      chk({30'h0, rsp}, {30'h0, `TMRB_RESP_SLVERR});
      // loaded but not started: value must hold
      wr(A_M0, 32'h0);
      wr(A_C0, 32'h1234);
      repeat (20) @(posedge ref_clk);
      rd(A_C0);
      chk(rd_v, 32'h1234);
      // low byte only: high byte keeps its old value
      s_axi_wstrb <= 4'h1;
      wr(A_C0, 32'hABCD);
      s_axi_wstrb <= 4'hF;
      rd(A_C0);
      chk(rd_v, 32'h12CD);
   endtask

   task automatic t_reload();
      int i;
      wr(A_C0, 32'h3);
      wr(`TMRB_OFS_MASK, 32'h0);
      wr(`TMRB_OFS_START, 32'h1);
      for (i = 0; i < 8; i++) begin
         rd(A_C0);
         chk({31'h0, rd_v <= 32'h3 || rd_v == 32'h0000_FFFF}, 32'h1);
      end
      wr(A_M0, 32'h40);
      rd(A_M0);
      chk(rd_v, 32'h0);
      rd(`TMRB_OFS_STAT);
      chk(rd_v, 32'h1);
      chk({31'h0, irq}, 32'h0);
      wr(`TMRB_OFS_MASK, 32'h1);
      repeat (2) @(posedge ref_clk);
      chk({31'h0, irq}, 32'h1);
      wr(`TMRB_OFS_START, 32'h0);
      wr(`TMRB_OFS_STAT, 32'h1);
      rd(`TMRB_OFS_STAT);
      chk(rd_v, 32'h0);
      repeat (2) @(posedge ref_clk);
      chk({31'h0, irq}, 32'h0);
   endtask

   task automatic t_event();
      wr(A_M2, 32'h05);
      wr(A_C2, 32'h5);
      wr(`TMRB_OFS_START, 32'h4);
      hi_w  <= 8'h03;
      lo_w  <= 8'h03;
      n_per <= 8'h03;
      go    <= 1'b1;
      repeat (30) @(posedge ref_clk);
      go <= 1'b0;
      rd(A_C2);
      chk(rd_v, 32'h2);
      wr(`TMRB_OFS_START, 32'h0);
   endtask

   task automatic t_measure();
      wr(`TMRB_OFS_STAT, 32'h7);
      wr(`TMRB_OFS_MASK, 32'h2);
      wr(A_M1, 32'h06);
      wr(A_C1, 32'h0);
      wr(`TMRB_OFS_START, 32'h2);
      hi_w  <= 8'h0A;
      lo_w  <= 8'h0A;
      n_per <= 8'h00;
      go    <= 1'b1;
      repeat (12) @(posedge ref_clk);
      rd(`TMRB_OFS_STAT);
      chk(rd_v, 32'h0);
      repeat (30) @(posedge ref_clk);
      rd(`TMRB_OFS_STAT);
      chk(rd_v, 32'h2);
      rd(A_C1);
      chk(rd_v, 32'h13);
      chk({31'h0, irq}, 32'h1);
      wr(`TMRB_OFS_START, 32'h0);
      go <= 1'b0;
      wr(A_M1, 32'h0A);
      wr(`TMRB_OFS_START, 32'h2);
      hi_w <= 8'h06;
      lo_w <= 8'h0E;
      go   <= 1'b1;
      repeat (60) @(posedge ref_clk);
      rd(A_C1);
      chk({31'h0, rd_v == 32'h5 || rd_v == 32'hD}, 32'h1);
      go <= 1'b0;
      wr(`TMRB_OFS_START, 32'h0);
   endtask

   task automatic t_overflow();
      // pulse idle so no edge meets the overflow; count preset in timer mode
      go <= 1'b0;
      wr(A_C0, 32'hFFF0);
      wr(A_M0, 32'h02);
      wr(`TMRB_OFS_STAT, 32'h7);
      wr(`TMRB_OFS_START, 32'h1);
      repeat (40) @(posedge ref_clk);
      rd(`TMRB_OFS_STAT);
      chk(rd_v, 32'h1);
      rd(A_M0);
      chk(rd_v, 32'h22);
      // a clear while stopped must be ignored
      wr(`TMRB_OFS_START, 32'h0);
      wr(A_M0, 32'h02);
      rd(A_M0);
      chk(rd_v, 32'h22);
      wr(`TMRB_OFS_START, 32'h1);
      repeat (4) @(posedge ref_clk);
      wr(A_M0, 32'h02);
      rd(A_M0);
      chk(rd_v, 32'h02);
      wr(`TMRB_OFS_START, 32'h0);
   endtask

   initial begin
      n_fail = 0;
      n_compared = 0;
      n_cyc = 0;
      rstn = 1'b0;
      s_axi_awaddr = 8'h00;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 8'h00;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      go = 1'b0;
      hi_w = 8'h01;
      lo_w = 8'h01;
      n_per = 8'h00;
      repeat (6) @(posedge ref_clk);
      rstn <= 1'b1;
      repeat (4) @(posedge ref_clk);
      t_reset();
      t_reload();
      t_event();
      t_measure();
      t_overflow();
      complete_run();
   end
endmodule
